// ===== rtl/can_protocol_controller.sv
// Functional notes
// - Thirty-two message objects in private RAM, each transmit or receive, with mask.
// - Bit rates up to 1 Mbit/s supported.
// - Standard and extended frames handled, 2.0A networks interoperate.
// - Controller does framing and acceptance filtering itself.
// - Only logic-level transmit and receive pins; no transceiver inside.
// - Frames shift serially out and in, converted to parallel contents.
// - All configuration and data pass through host register ports.
// - Controller clock derived from system clock via divider of 1, 2, 4 or 8; no 25 MHz cap applied.
// - Divider 1: read right after write returns the new value.
// - Other registers may be accessed with no delay after a write.
// - Time quantum is controller clock period times prescaler.
// - Prescaler equals extension:brp_low value plus one; extension resets to zero.
// - Bit has three segments (sync, pre, post); bit time is their sum.
// - Synchronisation segment is exactly one quantum, except after a hard sync, which restarts the bit in the pre segment.
// - Timing and extension writes only taken while unlock bit set.
// - Timing register fields: post at 12, pre at 8, jump at 6, prescaler low.
`timescale 1ns/1ps
`include "can_ctrl_map.svh"
module can_protocol_controller #(
  parameter int OBJS = `OBJ_COUNT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] register_page_select,
  input wire logic [1:0] core_clock_divider_reg,
  input wire logic setup_hold,
  input wire logic timing_write_unlock,
  input wire logic bt_we,
  input wire logic [15:0] bt_wdata,
  input wire logic prescaler_extension_we,
  input wire logic [3:0] prescaler_extension_wdata,
  input wire logic obj_we,
  input wire logic [4:0] obj_addr,
  input wire can_ctrl_pkg::msg_obj_type obj_wdata,
  input wire logic [4:0] obj_raddr,
  input wire logic tx_request,
  input wire logic [4:0] tx_obj,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  output logic [15:0] bt_rdata,
  output logic [3:0] prescaler_extension_rdata,
  output can_ctrl_pkg::msg_obj_type obj_rdata,
  output logic tx_busy,
  output logic rx_done,
  output logic [4:0] rx_obj
);
  can_ctrl_pkg::bit_timing_type bt_ff, nxt_bt;
  logic [3:0] prescaler_extension_ff, nxt_prescaler_extension;
  logic [2:0] div_cnt_ff, nxt_div_cnt;
  logic can_clk_en, page_ok, sample_pulse, bit_start_pulse, run;
  logic [4:0] ram_raddr;
  can_ctrl_pkg::msg_obj_type ram_rdata;
  logic ram_we;
  logic [4:0] ram_waddr;
  can_ctrl_pkg::msg_obj_type ram_wdata;
  logic [127:0] tx_sh_ff, nxt_tx_sh;
  logic [7:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] frame_len_ff, nxt_frame_len;
  logic tx_act_ff, nxt_tx_act, rx_act_ff, nxt_rx_act;
  logic [127:0] rx_sh_ff, nxt_rx_sh;
  logic [4:0] scan_ff, nxt_scan;
  logic scan_act_ff, nxt_scan_act;
  logic rx_done_ff, nxt_rx_done;
  logic [4:0] rx_obj_ff, nxt_rx_obj;
  logic prev_rx_ff;
  logic [28:0] rx_id;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data;
  logic rx_xtd;
  logic rx_start;
  logic frame_end;

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  function automatic logic id_hit(input can_ctrl_pkg::msg_obj_type o, input logic [28:0] id,
                                  input logic xtd);
    id_hit = o.object_valid_flag && !o.dir_tx && (o.xtd == xtd) &&
             (((o.id ^ id) & o.mask) == 29'h0);
  endfunction

  assign page_ok = (register_page_select == `PAGE_CAN);
  // Divider runs the core at the 100 MHz clock divided by 1, 2, 4 or 8; nothing holds it to 25 MHz or less
  // Every bit timing step rides on this enable, so the top rate follows from it
  assign can_clk_en = (div_cnt_ff == div_mask(core_clock_divider_reg));
  assign run = !setup_hold;

  always_comb begin
    nxt_div_cnt = can_clk_en ? 3'h0 : div_cnt_ff + 3'h1;
    nxt_bt = bt_ff;
    nxt_prescaler_extension = prescaler_extension_ff;
    if (page_ok && timing_write_unlock && setup_hold) begin
      if (bt_we) begin
        nxt_bt = bt_wdata;
      end
      if (prescaler_extension_we) begin
        nxt_prescaler_extension = prescaler_extension_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_ff <= 3'h0;
      bt_ff <= `BT_RESET;
      prescaler_extension_ff <= `PRESCALER_EXTENSION_RESET;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      bt_ff <= nxt_bt;
      prescaler_extension_ff <= nxt_prescaler_extension;
    end
  end

  // Registers are plain flops on core_clk, so readback is immediate
  assign bt_rdata = bt_ff;
  assign prescaler_extension_rdata = prescaler_extension_ff;

  bit_timer u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .can_clk_en(can_clk_en),
    .run(run),
    // Hard sync on the start edge; no soft resync, so long frames need matched clocks
    .resync(rx_start),
    .bt(bt_ff),
    .prescaler_extension(prescaler_extension_ff),
    .sample_pulse(sample_pulse),
    .bit_start_pulse(bit_start_pulse)
  );

  // Host port has priority on the RAM; received frames lose a write slot only then
  assign ram_we = (obj_we && page_ok) || (scan_act_ff && id_hit(ram_rdata, rx_id, rx_xtd));
  assign ram_waddr = (obj_we && page_ok) ? obj_addr : scan_ff;
  always_comb begin
    ram_wdata = obj_wdata;
    if (!(obj_we && page_ok)) begin
      ram_wdata = ram_rdata;
      ram_wdata.id = rx_id;
      ram_wdata.dlc = rx_dlc;
      ram_wdata.data = rx_data;
    end
  end
  // Scan address runs one ahead, so each object is ready in the cycle it is judged
  // Using the next scan state also fetches object 0 in the cycle the scan opens
  assign ram_raddr = nxt_scan_act ? nxt_scan : (tx_request ? tx_obj : obj_raddr);

  msg_ram #(.DEPTH(OBJS), .AW(5)) u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );
  assign obj_rdata = ram_rdata;

  // Simplified frame: xtd flag, 29-bit id, dlc, 64 data bits; no stuffing or CRC
  assign rx_xtd = rx_sh_ff[97];
  assign rx_id = rx_xtd ? rx_sh_ff[96:68] : {18'h0, rx_sh_ff[96:86]};
  assign rx_dlc = rx_sh_ff[67:64];
  assign rx_data = rx_sh_ff[63:0];

  // Falling receive edge while idle opens a frame; a pending request keeps priority
  assign rx_start = run && !tx_act_ff && !rx_act_ff && !tx_request && prev_rx_ff &&
                    !bus_receive_pin;
  // Frame closes at the sample of its last bit, whichever direction it runs
  assign frame_end = sample_pulse && (bit_cnt_ff + 8'h01 == frame_len_ff);

  always_comb begin
    nxt_tx_sh = tx_sh_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_frame_len = frame_len_ff;
    nxt_tx_act = tx_act_ff;
    nxt_rx_act = rx_act_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_scan = scan_ff;
    nxt_scan_act = scan_act_ff;
    nxt_rx_done = 1'b0;
    nxt_rx_obj = rx_obj_ff;
    if (!run) begin
      nxt_tx_act = 1'b0;
      nxt_rx_act = 1'b0;
      nxt_scan_act = 1'b0;
    end else begin
      if (tx_request && !tx_act_ff && !rx_act_ff && ram_rdata.dir_tx &&
          ram_rdata.object_valid_flag) begin
        nxt_tx_sh = {29'h0, 1'b0, ram_rdata.xtd, ram_rdata.xtd ? ram_rdata.id :
                     {ram_rdata.id[10:0], 18'h0}, ram_rdata.dlc, ram_rdata.data};
        nxt_tx_act = 1'b1;
        nxt_bit_cnt = 8'h00;
        nxt_frame_len = 8'h63;
      end else if (rx_start) begin
        nxt_rx_act = 1'b1;
        nxt_bit_cnt = 8'h00;
        nxt_frame_len = 8'h63;
      end
      if (sample_pulse && (tx_act_ff || rx_act_ff)) begin
        nxt_rx_sh = {rx_sh_ff[126:0], bus_receive_pin};
        nxt_bit_cnt = bit_cnt_ff + 8'h01;
        if (frame_end) begin
          nxt_tx_act = 1'b0;
          nxt_rx_act = 1'b0;
          nxt_scan_act = rx_act_ff;
          nxt_scan = 5'h00;
        end
      end
      if (bit_start_pulse && tx_act_ff && bit_cnt_ff != 8'h00) begin
        nxt_tx_sh = {tx_sh_ff[126:0], 1'b1};
      end
      if (scan_act_ff) begin
        if (id_hit(ram_rdata, rx_id, rx_xtd) && !(obj_we && page_ok)) begin
          nxt_scan_act = 1'b0;
          nxt_rx_done = 1'b1;
          nxt_rx_obj = scan_ff;
        end else if (scan_ff == 5'h1F) begin
          nxt_scan_act = 1'b0;
        end else begin
          nxt_scan = scan_ff + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_ff <= {128{1'b1}};
      bit_cnt_ff <= 8'h00;
      frame_len_ff <= 8'h00;
      tx_act_ff <= 1'b0;
      rx_act_ff <= 1'b0;
      rx_sh_ff <= 128'h0;
      scan_ff <= 5'h00;
      scan_act_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_obj_ff <= 5'h00;
      prev_rx_ff <= 1'b1;
    end else begin
      tx_sh_ff <= nxt_tx_sh;
      bit_cnt_ff <= nxt_bit_cnt;
      frame_len_ff <= nxt_frame_len;
      tx_act_ff <= nxt_tx_act;
      rx_act_ff <= nxt_rx_act;
      rx_sh_ff <= nxt_rx_sh;
      scan_ff <= nxt_scan;
      scan_act_ff <= nxt_scan_act;
      rx_done_ff <= nxt_rx_done;
      rx_obj_ff <= nxt_rx_obj;
      prev_rx_ff <= bus_receive_pin;
    end
  end

  // Recessive high whenever idle or held in setup
  assign bus_transmit_pin = (tx_act_ff && run) ? tx_sh_ff[98] : 1'b1;
  assign tx_busy = tx_act_ff;
  assign rx_done = rx_done_ff;
  assign rx_obj = rx_obj_ff;
endmodule

// ===== shared/can_ctrl_map.svh
`ifndef CAN_CTRL_MAP_SVH
`define CAN_CTRL_MAP_SVH
`define OBJ_COUNT 32
`define PAGE_CAN 8'h0C
`define BT_RESET 16'h2301
`define PRESCALER_EXTENSION_RESET 4'h0
`define BT_POST_LSB 12
`define BT_PRE_LSB 8
`define BT_SJW_LSB 6
`define BT_BRP_LSB 0
`define CORE_CLK_MHZ 100
`define CAN_CLK_MAX_MHZ 25
`define MAX_BIT_RATE_KBPS 1000
`define SYNC_SEG_TQ 1
`endif

// ===== shared/can_ctrl_pkg.sv
package can_ctrl_pkg;
  typedef enum logic [1:0] {DIV1, DIV2, DIV4, DIV8} clk_div_type;
  typedef struct packed {
    logic [3:0] post_sample_segment_field;
    logic [3:0] pre_sample_segment_field;
    logic [1:0] jump_width_field;
    logic [5:0] brp_low;
  } bit_timing_type;
  typedef struct packed {
    logic [28:0] id;
    logic [28:0] mask;
    logic xtd;
    logic dir_tx;
    logic object_valid_flag;
    logic [3:0] dlc;
    logic [63:0] data;
  } msg_obj_type;
  typedef enum logic [1:0] {SEG_SYNC, SEG_PRE, SEG_POST} seg_state_type;
endpackage

// ===== rtl/msg_ram.sv
`timescale 1ns/1ps
module msg_ram #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire can_ctrl_pkg::msg_obj_type wdata,
  input wire logic [AW-1:0] raddr,
  output can_ctrl_pkg::msg_obj_type rdata
);
  can_ctrl_pkg::msg_obj_type mem [DEPTH];
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== rtl/bit_timer.sv
`timescale 1ns/1ps
`include "can_ctrl_map.svh"
module bit_timer (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic can_clk_en,
  input wire logic run,
  input wire logic resync,
  input wire can_ctrl_pkg::bit_timing_type bt,
  input wire logic [3:0] prescaler_extension,
  output logic sample_pulse,
  output logic bit_start_pulse
);
  logic [9:0] tq_cnt_ff, nxt_tq_cnt;
  logic [4:0] seg_cnt_ff, nxt_seg_cnt;
  can_ctrl_pkg::seg_state_type seg_ff, nxt_seg;
  logic [9:0] brp;
  logic tq_en;
  assign brp = {prescaler_extension, bt.brp_low};
  assign tq_en = can_clk_en && (tq_cnt_ff == brp);
  always_comb begin
    nxt_tq_cnt = tq_cnt_ff;
    nxt_seg_cnt = seg_cnt_ff;
    nxt_seg = seg_ff;
    sample_pulse = 1'b0;
    bit_start_pulse = 1'b0;
    if (!run) begin
      nxt_tq_cnt = 10'h000;
      nxt_seg_cnt = 5'h00;
      nxt_seg = can_ctrl_pkg::SEG_SYNC;
    end else if (resync) begin
      nxt_tq_cnt = 10'h000;
      nxt_seg_cnt = 5'h00;
      nxt_seg = can_ctrl_pkg::SEG_PRE;
    end else if (can_clk_en) begin
      nxt_tq_cnt = tq_en ? 10'h000 : tq_cnt_ff + 10'h001;
      if (tq_en) begin
        case (seg_ff)
          can_ctrl_pkg::SEG_SYNC: begin
            bit_start_pulse = 1'b1;
            nxt_seg = can_ctrl_pkg::SEG_PRE;
            nxt_seg_cnt = 5'h00;
          end
          can_ctrl_pkg::SEG_PRE: begin
            if (seg_cnt_ff[3:0] == bt.pre_sample_segment_field) begin
              sample_pulse = 1'b1;
              nxt_seg = can_ctrl_pkg::SEG_POST;
              nxt_seg_cnt = 5'h00;
            end else begin
              nxt_seg_cnt = seg_cnt_ff + 5'h01;
            end
          end
          can_ctrl_pkg::SEG_POST: begin
            if (seg_cnt_ff[3:0] == bt.post_sample_segment_field) begin
              nxt_seg = can_ctrl_pkg::SEG_SYNC;
              nxt_seg_cnt = 5'h00;
            end else begin
              nxt_seg_cnt = seg_cnt_ff + 5'h01;
            end
          end
          default: nxt_seg = can_ctrl_pkg::SEG_SYNC;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tq_cnt_ff <= 10'h000;
      seg_cnt_ff <= 5'h00;
      seg_ff <= can_ctrl_pkg::SEG_SYNC;
    end else begin
      tq_cnt_ff <= nxt_tq_cnt;
      seg_cnt_ff <= nxt_seg_cnt;
      seg_ff <= nxt_seg;
    end
  end
endmodule

// ===== verification/can_ctrl_monitor.sv
`timescale 1ns/1ps
module can_ctrl_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] register_page_select,
  input wire logic setup_hold,
  input wire logic timing_write_unlock,
  input wire logic bt_we,
  input wire logic [15:0] bt_wdata,
  input wire logic prescaler_extension_we,
  input wire logic [3:0] prescaler_extension_wdata,
  input wire logic tx_request,
  input wire logic bus_transmit_pin,
  input wire logic [15:0] bt_rdata,
  input wire logic [3:0] prescaler_extension_rdata,
  input wire logic tx_busy,
  input wire logic rx_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic open_w;
  assign open_w = register_page_select == 8'h0C && timing_write_unlock && setup_hold;
  bt_take_a: assert property (bt_we && open_w |=> bt_rdata == $past(bt_wdata))
    else $error("timing write not taken");
  bt_refuse_a: assert property (!(bt_we && open_w) |=> $stable(bt_rdata))
    else $error("timing register changed without accepted write");
  ext_take_a: assert property (prescaler_extension_we && open_w |=> prescaler_extension_rdata == $past(prescaler_extension_wdata))
    else $error("extension write not taken");
  ext_refuse_a: assert property (!(prescaler_extension_we && open_w) |=> $stable(prescaler_extension_rdata))
    else $error("extension changed without accepted write");
  hold_recessive_a: assert property (setup_hold [*2] |-> bus_transmit_pin)
    else $error("transmit pin dominant during hold");
  hold_silent_a: assert property (setup_hold |=> !$rose(tx_busy))
    else $error("transfer started during hold");
  done_pulse_a: assert property (rx_done |=> !rx_done)
    else $error("receive done longer than one cycle");
  tx_cause_a: assert property ($rose(tx_busy) |-> $past(tx_request))
    else $error("transfer started without request");
endmodule

// ===== verification/can_bus_node.sv
`timescale 1ns/1ps
module can_bus_node (
  input wire logic core_clk,
  input wire logic bus_transmit_pin,
  input wire logic drive_dominant,
  output logic bus_receive_pin
);
  logic frame_dom = 1'b0;
  // Wired-AND bus seen through the transceiver: any dominant 0 wins
  assign bus_receive_pin = bus_transmit_pin & ~drive_dominant & ~frame_dom;
  // Remote node: each bit held one full bit time, changed just after an edge
  task automatic send_frame(input logic [98:0] bits, input int bit_cyc);
    for (int i = 98; i >= 0; i--) begin
      frame_dom = ~bits[i];
      repeat (bit_cyc) @(posedge core_clk);
      #1;
    end
    frame_dom = 1'b0;
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] bt;
    logic [3:0] ext;
    logic [1:0] div;
    logic unl;
    logic [15:0] exp_bt;
    int bit_cyc;
  } row_type;
  // Bit cycles = divider * (ext:brp_low + 1) * (1 + pre + 1 + post + 1)
  row_type rows[5] = '{
    '{16'h2301, 4'h0, 2'h0, 1'b1, 16'h2301, 16},
    '{16'h6FC0, 4'h0, 2'h0, 1'b1, 16'h6FC0, 24},
    '{16'h1100, 4'h1, 2'h1, 1'b1, 16'h1100, 650},
    '{16'h1A41, 4'h0, 2'h3, 1'b1, 16'h1A41, 224},
    '{16'h6FC0, 4'h3, 2'h0, 1'b0, 16'h2301, 16}
  };
  logic core_clk, reset_n, setup_hold, timing_write_unlock, bt_we, prescaler_extension_we, obj_we;
  logic tx_request, drive_dominant, bus_receive_pin, bus_transmit_pin;
  logic tx_busy, rx_done;
  logic [7:0] register_page_select;
  logic [1:0] core_clock_divider_reg;
  logic [15:0] bt_wdata, bt_rdata;
  logic [3:0] prescaler_extension_wdata, prescaler_extension_rdata;
  logic [4:0] obj_addr, obj_raddr, tx_obj, rx_obj;
  can_ctrl_pkg::msg_obj_type obj_wdata, obj_rdata, obj;
  int num_errors = 0;
  int num_checks = 0;
  int c1;
  int w;

  can_protocol_controller u_can_protocol_controller (.core_clk, .reset_n,
    .register_page_select, .core_clock_divider_reg, .setup_hold, .timing_write_unlock,
    .bt_we, .bt_wdata, .prescaler_extension_we, .prescaler_extension_wdata, .obj_we, .obj_addr, .obj_wdata, .obj_raddr,
    .tx_request, .tx_obj, .bus_receive_pin, .bus_transmit_pin, .bt_rdata, .prescaler_extension_rdata,
    .obj_rdata, .tx_busy, .rx_done, .rx_obj);
  can_bus_node u_can_bus_node (.core_clk, .bus_transmit_pin, .drive_dominant,
    .bus_receive_pin);

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    tick(20);
    reset_n = 1'b1;
    check("bt_reset", bt_rdata, 16'h2301);
    check("ext_reset", prescaler_extension_rdata, 4'h0);
    check("pin_reset", bus_transmit_pin, 1'b1);
    check("busy_reset", tx_busy, 1'b0);
  endtask
  task automatic wr_bt(input logic [15:0] d);
    bt_wdata = d;
    bt_we = 1'b1;
    tick;
    bt_we = 1'b0;
  endtask
  task automatic load_and_send;
    obj_we = 1'b1;
    tick;
    obj_we = 1'b0;
    tick;
    check("obj_rdata", obj_rdata === obj, 1'b1);
    tx_request = 1'b1;
    tick;
    tx_request = 1'b0;
  endtask
  // Start bit low, then the extended flag high; its width is one bit time
  task automatic measure(output int c);
    int w;
    w = 0;
    c = 0;
    while (bus_transmit_pin !== 1'b0 && w < 2000) begin
      tick;
      w++;
    end
    while (bus_transmit_pin === 1'b0 && w < 4000) begin
      tick;
      w++;
    end
    while (bus_transmit_pin === 1'b1 && c < 2000) begin
      tick;
      c++;
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {reset_n, setup_hold, timing_write_unlock, bt_we, prescaler_extension_we, obj_we} = 6'h00;
    {tx_request, drive_dominant, bt_wdata, prescaler_extension_wdata} = 22'h000000;
    register_page_select = 8'h0C;
    core_clock_divider_reg = 2'h0;
    obj = '0;
    obj.xtd = 1'b1;
    obj.dir_tx = 1'b1;
    obj.object_valid_flag = 1'b1;
    obj.id = 29'h0AAAAAAA;
    obj.data = 64'h0123456789ABCDEF;
    obj_wdata = obj;
    {obj_addr, obj_raddr, tx_obj} = {3{5'h07}};
    foreach (rows[i]) begin
      do_reset;
      core_clock_divider_reg = rows[i].div;
      setup_hold = 1'b1;
      timing_write_unlock = rows[i].unl;
      wr_bt(rows[i].bt);
      prescaler_extension_wdata = rows[i].ext;
      prescaler_extension_we = 1'b1;
      check("bt_rdata", bt_rdata, rows[i].exp_bt);
      tick;
      prescaler_extension_we = 1'b0;
      check("ext_rdata", prescaler_extension_rdata, rows[i].unl ? rows[i].ext : 4'h0);
      {setup_hold, timing_write_unlock} = 2'b00;
      load_and_send;
      check("tx_busy", tx_busy, 1'b1);
      measure(c1);
      check("bit_cycles", c1, rows[i].bit_cyc);
    end
    do_reset;
    timing_write_unlock = 1'b1;
    setup_hold = 1'b1;
    register_page_select = 8'h0B;
    wr_bt(16'h6FC0);
    check("bt_wrong_page", bt_rdata, 16'h2301);
    register_page_select = 8'h0C;
    setup_hold = 1'b0;
    wr_bt(16'h6FC0);
    check("bt_no_hold", bt_rdata, 16'h2301);
    setup_hold = 1'b1;
    wr_bt(16'h1A41);
    wr_bt(16'h6FC0);
    check("bt_back_to_back", bt_rdata, 16'h6FC0);
    load_and_send;
    check("busy_in_hold", tx_busy, 1'b0);
    tick(50);
    check("pin_in_hold", bus_transmit_pin, 1'b1);
    do_reset;
    setup_hold = 1'b1;
    obj_wdata = '0;
    obj_we = 1'b1;
    for (int a = 0; a < 32; a++) begin
      obj_addr = a[4:0];
      tick;
    end
    obj_wdata.object_valid_flag = 1'b1;
    obj_wdata.xtd = 1'b1;
    obj_wdata.mask = {29{1'b1}};
    obj_wdata.id = 29'h0ABCDF01;
    obj_addr = 5'h02;
    tick;
    obj_wdata.id = 29'h0ABCDE0E;
    obj_wdata.mask = 29'h1FFFFFF0;
    obj_addr = 5'h03;
    tick;
    obj_we = 1'b0;
    setup_hold = 1'b0;
    tick(2);
    fork
      u_can_bus_node.send_frame({1'b0, 1'b1, 29'h0ABCDE01, 4'h8, 64'hFEDCBA9876543211}, 16);
    join_none
    w = 0;
    while (rx_done !== 1'b1 && w < 3000) begin
      tick;
      w++;
    end
    check("rx_done", rx_done, 1'b1);
    check("rx_obj", rx_obj, 5'h03);
    tick;
    check("rx_done_pulse", rx_done, 1'b0);
    obj_raddr = 5'h03;
    tick(20);
    check("rx_id", obj_rdata.id, 29'h0ABCDE01);
    check("rx_data", obj_rdata.data === 64'hFEDCBA9876543211, 1'b1);
    obj_raddr = 5'h02;
    tick(2);
    check("rx_miss", obj_rdata.id, 29'h0ABCDF01);
    tally_and_finish;
  end
endmodule

bind can_protocol_controller can_ctrl_monitor u_can_ctrl_monitor (.core_clk, .reset_n,
  .register_page_select, .setup_hold, .timing_write_unlock, .bt_we, .bt_wdata, .prescaler_extension_we,
  .prescaler_extension_wdata, .tx_request, .bus_transmit_pin, .bt_rdata, .prescaler_extension_rdata, .tx_busy, .rx_done);
